// >>> design/btc_addr_pair.sv
/*
 * holds the incrementing current address and final address pair.
 * assumes the caller gives at most one of load or step per cycle.
 */
`timescale 1ns/1ps
`include "btc_cfg.svh"

module btc_addr_pair #(
	parameter int AW = 16
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          loadCur,
	input  wire logic          loadFin,
	input  wire logic [AW-1:0] loadValue,
	input  wire logic          step,
	output logic      [AW-1:0] curAddr,
	output logic      [AW-1:0] finAddr
);

	typedef struct packed {
		logic [AW-1:0] cur;
		logic [AW-1:0] fin;
	} btc_addr_type;

	btc_addr_type state;
	btc_addr_type next_state;

	// -------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------
	always_comb begin
		next_state = state;
		if (loadCur) begin
			next_state.cur = loadValue;
		end else if (step) begin
			// wraps to zero; caller watches the rollover
			next_state.cur = state.cur + {{(AW-1){1'b0}}, 1'b1};
		end
		if (loadFin) begin
			next_state.fin = loadValue;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign curAddr = state.cur;
	assign finAddr = state.fin;

endmodule // btc_addr_pair

// >>> design/btc_cfg.svh
/*
 * constants of the block transfer channel control: device number default,
 * command and status bit positions, peripheral status bit positions.
 * assumes bit 0 is the least significant bit of every byte in this design.
 */
`ifndef BTC_CFG_SVH
`define BTC_CFG_SVH

// -----------------------------------------------------------------------
// identity
// -----------------------------------------------------------------------
`define BTC_DEV_NUM        8'hf0

// -----------------------------------------------------------------------
// command byte bits, lsb numbered 0
// -----------------------------------------------------------------------
`define BTC_CMD_READ       5
`define BTC_CMD_GO         4
`define BTC_CMD_STOP       3

// -----------------------------------------------------------------------
// status byte bits, lsb numbered 0
// -----------------------------------------------------------------------
`define BTC_STS_BUSY       3
`define BTC_STS_IDLE_BYTE  8'h08
`define BTC_STS_EXAMINE    7
`define BTC_STS_EOM        5
`define BTC_STS_FAULT      2

// -----------------------------------------------------------------------
// address loading
// -----------------------------------------------------------------------
`define BTC_ADDR_BYTES     2'h3
`define BTC_ZERO16         16'h0000
`define BTC_ONES16         16'hffff

`endif

// >>> design/btc_channel.sv
/*
 * control of a block transfer channel: status, commands, termination,
 * interrupt and acknowledge, address loading and read-back, initialization.
 * assumes the processor issues one i/o operation per cycle as a pulse with
 * its device number; memory cycles are handled outside and report each
 * finished halfword on wordDone.
 */
//
// Operation
// - status sense returns the status byte; low nibble feeds condition code
// - idle or terminated: peripheral status shown, busy bit forced zero
// - output command byte is accepted and its bits are acted upon
// - current address equal to final address ends transfer normally
// - current address rolling from all ones to zero ends abnormally
// - peripheral fault, end of medium or examine bit ends abnormally
// - stop command terminates any transfer in progress
// - busy may fall before idle; only stop guarantees idle
// - busy bit high during transfer, cleared on termination
// - during transfer status byte holds only the busy bit
// - go enables interrupt; termination requests it, processor gates it
// - acknowledge clears pending interrupt, returns device number and status
// - addressing the channel before acknowledge loses the interrupt
// - last address read as high then low byte, or as halfword
// - initialize or stop: halt, write mode, idle, interrupt reset
// - channel answers a fixed device number, default f0
// - read command selects read mode; reverts to write after each transfer
// - go starts transfer, may share byte with read
// - two 16-bit addresses loaded by four byte writes, high first
`timescale 1ns/1ps
`include "btc_cfg.svh"

module btc_channel #(
	parameter logic [7:0] DEV_NUM = `BTC_DEV_NUM,
	parameter int         AW      = 16
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          initSwitch,
	input  wire logic [7:0]    opDevice,
	input  wire logic          senseStatusOp,
	input  wire logic          outputCommandOp,
	input  wire logic          writeDataOp,
	input  wire logic          writeHalfOp,
	input  wire logic          readDataOp,
	input  wire logic          readHalfOp,
	input  wire logic          interruptAckOp,
	input  wire logic [15:0]   opData,
	input  wire logic [7:0]    peripheralStatus,
	input  wire logic          wordDone,
	output logic      [7:0]    statusByte,
	output logic      [3:0]    conditionCode,
	output logic      [15:0]   readData,
	output logic      [7:0]    ackDevice,
	output logic               ackValid,
	output logic               interruptRequest,
	output logic               transferActive,
	output logic               readMode,
	output logic      [AW-1:0] memAddr,
	output logic      [1:0]    lastTermination
);

	typedef struct packed {
		btc_pkg::btc_mode_type mode;
		btc_pkg::btc_term_type term;
		logic                  readSel;
		logic                  irqEnable;
		logic                  irqPending;
		logic [1:0]            wrIndex;
		logic                  rdLow;
		logic [AW-1:0]         lastAddr;
		logic [7:0]            status;
		logic [3:0]            cc;
		logic [15:0]           rdData;
		logic [7:0]            ackDev;
		logic                  ackOk;
	} btc_state_type;

	btc_state_type state;
	btc_state_type next_state;

	logic [AW-1:0] curAddr;
	logic [AW-1:0] finAddr;
	logic          loadCur;
	logic          loadFin;
	logic [AW-1:0] loadValue;
	logic          step;

	// -------------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------------
	function automatic logic addressed(input logic op, input logic [7:0] dev);
		return op && (dev == DEV_NUM);
	endfunction

	// idle and terminated views share this byte
	function automatic logic [7:0] idleStatus(input logic [7:0] periph);
		logic [7:0] s;
		s = periph;
		s[`BTC_STS_BUSY] = 1'b0;
		return s;
	endfunction

	logic selSense;
	logic selCmd;
	logic selWd;
	logic selWh;
	logic selRd;
	logic selRh;
	logic selAck;
	logic anySel;
	logic busy;
	logic isMatch;
	logic isRoll;
	logic isFault;
	logic doStop;
	logic doGo;

	assign selSense = addressed(senseStatusOp, opDevice);
	assign selCmd   = addressed(outputCommandOp, opDevice);
	assign selWd    = addressed(writeDataOp, opDevice);
	assign selWh    = addressed(writeHalfOp, opDevice);
	assign selRd    = addressed(readDataOp, opDevice);
	assign selRh    = addressed(readHalfOp, opDevice);
	assign selAck   = addressed(interruptAckOp, opDevice);
	assign anySel   = selSense | selCmd | selWd | selWh | selRd | selRh | selAck;
	assign busy     = state.mode == btc_pkg::ModeBusy;

	// -------------------------------------------------------------------
	// termination causes
	// -------------------------------------------------------------------
	assign isMatch = wordDone && (curAddr == finAddr);
	// a match on the last word wins over the wrap
	assign isRoll  = wordDone && (curAddr == `BTC_ONES16);
	assign isFault = peripheralStatus[`BTC_STS_FAULT]
		| peripheralStatus[`BTC_STS_EOM]
		| peripheralStatus[`BTC_STS_EXAMINE];

	assign doStop = initSwitch | (selCmd && opData[`BTC_CMD_STOP]);
	assign doGo   = selCmd && opData[`BTC_CMD_GO] && !opData[`BTC_CMD_STOP];

	// -------------------------------------------------------------------
	// address path
	// -------------------------------------------------------------------
	always_comb begin
		loadCur   = 1'b0;
		loadFin   = 1'b0;
		loadValue = curAddr;
		step      = 1'b0;
		if (!busy && selWh) begin
			loadValue = opData;
			loadCur   = (state.wrIndex == 2'h0);
			loadFin   = (state.wrIndex == 2'h2);
		end else if (!busy && selWd) begin
			loadCur = !state.wrIndex[1];
			loadFin = state.wrIndex[1];
			if (state.wrIndex[0]) begin
				loadValue = {(state.wrIndex[1] ? finAddr[15:8] : curAddr[15:8]),
					opData[7:0]};
			end else begin
				loadValue = {opData[7:0],
					(state.wrIndex[1] ? finAddr[7:0] : curAddr[7:0])};
			end
		end else if (busy && wordDone && !isMatch && !isRoll) begin
			step = 1'b1;
		end
	end

	btc_addr_pair #(
		.AW(AW)
	) uAddr (
		.clk      (clk),
		.rstn     (rstn),
		.loadCur  (loadCur),
		.loadFin  (loadFin),
		.loadValue(loadValue),
		.step     (step),
		.curAddr  (curAddr),
		.finAddr  (finAddr)
	);

	// -------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------
	always_comb begin
		next_state       = state;
		next_state.ackOk = 1'b0;

		if (selCmd && opData[`BTC_CMD_READ] && !busy) begin
			next_state.readSel = 1'b1;
		end
		if (doGo && state.mode == btc_pkg::ModeIdle) begin
			next_state.mode      = btc_pkg::ModeBusy;
			next_state.irqEnable = 1'b1;
			next_state.term      = btc_pkg::TermNone;
			next_state.wrIndex   = 2'h0;
		end

		if (busy) begin
			next_state.lastAddr = curAddr;
			if (isMatch || isRoll || isFault) begin
				// busy drops here, idle only after stop
				next_state.mode    = btc_pkg::ModeDone;
				next_state.readSel = 1'b0;
				next_state.term    = isMatch ? btc_pkg::TermNormal
					: (isRoll ? btc_pkg::TermRollover : btc_pkg::TermFault);
				if (state.irqEnable) begin
					next_state.irqPending = 1'b1;
				end
				next_state.irqEnable = 1'b0;
			end
		end

		if (selWd && !busy) begin
			next_state.wrIndex = state.wrIndex + 2'h1;
		end
		if (selWh && !busy) begin
			next_state.wrIndex = state.wrIndex + 2'h2;
		end

		if (selRd) begin
			next_state.rdData = {8'h00, state.rdLow ? state.lastAddr[7:0]
				: state.lastAddr[15:8]};
			next_state.rdLow  = !state.rdLow;
		end
		if (selRh) begin
			next_state.rdData = state.lastAddr;
			next_state.rdLow  = 1'b0;
		end

		if (selSense || selAck) begin
			next_state.cc = next_state.status[3:0];
		end

		if (selAck && state.irqPending) begin
			next_state.irqPending = 1'b0;
			next_state.ackDev     = DEV_NUM;
			next_state.ackOk      = 1'b1;
		end else if (anySel && !selAck && state.irqPending) begin
			// an early poll costs the interrupt
			next_state.irqPending = 1'b0;
		end

		// stop overrides the mode, read select, interrupt flags and byte indices set above
		if (doStop) begin
			next_state.mode       = btc_pkg::ModeIdle;
			next_state.readSel    = 1'b0;
			next_state.irqPending = 1'b0;
			next_state.irqEnable  = 1'b0;
			next_state.wrIndex    = 2'h0;
			next_state.rdLow      = 1'b0;
		end

		// status byte tracks mode every cycle
		next_state.status = (next_state.mode == btc_pkg::ModeBusy)
			? `BTC_STS_IDLE_BYTE : idleStatus(peripheralStatus);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state          <= '0;
			state.mode     <= btc_pkg::ModeIdle;
			state.term     <= btc_pkg::TermNone;
		end else begin
			state <= next_state;
		end
	end

	// -------------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------------
	assign statusByte       = state.status;
	assign conditionCode    = state.cc;
	assign readData         = state.rdData;
	assign ackDevice        = state.ackDev;
	assign ackValid         = state.ackOk;
	assign interruptRequest = state.irqPending;
	assign transferActive   = busy;
	assign readMode         = state.readSel;
	assign memAddr          = curAddr;
	assign lastTermination  = state.term;

endmodule // btc_channel

// >>> design/btc_pkg.sv
/*
 * types of the block transfer channel control.
 * assumes the cfg header is compiled alongside.
 */
package btc_pkg;

	typedef enum logic [1:0] {
		ModeIdle,
		ModeBusy,
		ModeDone
	} btc_mode_type;

	typedef enum logic [1:0] {
		TermNone,
		TermNormal,
		TermRollover,
		TermFault
	} btc_term_type;

endpackage

// >>> test/btc_channel_props.sv
/* checker of the channel control ports.
   assumes it is bound to btc_channel and sees only its ports. */
`timescale 1ns/1ps
module btc_channel_props #(
	parameter logic [7:0] DEV_NUM = 8'hf0
) (
	input wire logic       clk, rstn, initSwitch, senseStatusOp, outputCommandOp,
	input wire logic       writeDataOp, writeHalfOp, readDataOp, readHalfOp,
	input wire logic       interruptAckOp, ackValid, interruptRequest,
	input wire logic       transferActive, readMode,
	input wire logic [7:0] opDevice, peripheralStatus, statusByte, ackDevice,
	input wire logic [15:0] opData,
	input wire logic [3:0] conditionCode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire logic me = opDevice == DEV_NUM;
	wire logic anyOp = me && (senseStatusOp || outputCommandOp || writeDataOp ||
		writeHalfOp || readDataOp || readHalfOp || interruptAckOp);
	wire logic stopCmd = me && outputCommandOp && opData[3];
	busy_only_a: assert property (transferActive |-> statusByte == 8'h08)
		else $error("busy status not alone");
	idle_busy_a: assert property (!transferActive |-> !statusByte[3])
		else $error("busy bit set while idle");
	stop_idle_a: assert property ((stopCmd || initSwitch) |=>
		!transferActive && !interruptRequest && !readMode) else $error("stop not idle");
	ack_answer_a: assert property (me && interruptAckOp && interruptRequest |=>
		ackValid && ackDevice == DEV_NUM && !interruptRequest) else $error("bad ack");
	irq_hold_a: assert property (interruptRequest && !anyOp && !initSwitch |=>
		interruptRequest) else $error("irq dropped");
	irq_lost_a: assert property (interruptRequest && anyOp && !interruptAckOp |=>
		!interruptRequest) else $error("irq kept");
	term_irq_a: assert property ($fell(transferActive) && !$past(stopCmd) &&
		!$past(initSwitch) |-> interruptRequest && !readMode) else $error("no term irq");
	fault_end_a: assert property (transferActive && |(peripheralStatus & 8'ha4) |->
		##[1:2] !transferActive) else $error("fault ignored");
	sense_cc_a: assert property (me && senseStatusOp |=>
		conditionCode == $past(statusByte[3:0])) else $error("bad cc");
endmodule // btc_channel_props

// >>> test/btc_mem_model.sv
/* memory side model: pulses wordDone while a transfer runs, each cycle or slow.
   assumes transferActive comes from the channel under test. */
`timescale 1ns/1ps
module btc_mem_model (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic transferActive,
	input  wire logic slow,
	output logic      wordDone
);
	logic [1:0] gap;
	// stray pulse after the end is kept: a real memory may finish late
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gap      <= 2'h0;
			wordDone <= 1'b0;
		end else begin
			gap      <= gap + 2'h1;
			wordDone <= transferActive && (!slow || gap == 2'h3);
		end
	end
endmodule // btc_mem_model

// >>> test/test_block_transfer_channel_control.sv
/* bench of the channel control: one task per scenario, self-checking.
   assumes design, memory model and checker are compiled first. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module test_block_transfer_channel_control;
	logic        clk = 0, rstn = 0, initSwitch = 0, slow = 0, wordDone;
	logic [6:0]  ops = 7'h00;
	logic [7:0]  opDevice = 8'hf0, periph = 8'h00, statusByte, ackDevice;
	logic [15:0] opData = 16'h0000, readData, memAddr;
	logic [3:0]  conditionCode;
	logic [1:0]  lastTermination;
	logic        ackValid, interruptRequest, transferActive, readMode;
	int          n_errors = 0, check_count = 0;
	always #10 clk = ~clk;
	btc_channel dut_u (.clk, .rstn, .initSwitch, .opDevice, .senseStatusOp(ops[0]),
		.outputCommandOp(ops[1]), .writeDataOp(ops[2]), .writeHalfOp(ops[3]),
		.readDataOp(ops[4]), .readHalfOp(ops[5]), .interruptAckOp(ops[6]), .opData,
		.peripheralStatus(periph), .wordDone, .statusByte, .conditionCode, .readData,
		.ackDevice, .ackValid, .interruptRequest, .transferActive, .readMode,
		.memAddr, .lastTermination);
	btc_mem_model mem_u (.clk, .rstn, .transferActive, .slow, .wordDone);
	// op index: 0 sense, 1 command, 2 byte write, 3 half write, 4 byte read,
	// 5 half read, 6 acknowledge; idle cycle first so pulses never merge
	task automatic op(input int k, input logic [15:0] d);
		@(negedge clk);
		ops[k] = 1'b1;
		opData = d;
		@(negedge clk);
		ops = 7'h00;
	endtask
	task automatic load(input logic [15:0] s, input logic [15:0] f);
		op(1, 16'h0008);
		op(2, {8'h00, s[15:8]});
		op(2, {8'h00, s[7:0]});
		op(2, {8'h00, f[15:8]});
		op(2, {8'h00, f[7:0]});
	endtask
	// no channel op between go and acknowledge
	task automatic waitIrq;
		for (int i = 0; i < 300 && interruptRequest !== 1'b1; i++) @(negedge clk);
		`CHK("irq", 1'b1, interruptRequest)
	endtask
	task automatic t_normal;
		load(16'h0010, 16'h0013);
		op(1, 16'h0030);
		`CHK("busy", 8'h08, statusByte)
		`CHK("read mode", 1'b1, readMode)
		waitIrq();
		`CHK("term", 2'h1, lastTermination)
		`CHK("end addr", 16'h0013, memAddr)
		`CHK("write mode", 1'b0, readMode)
		op(6, 16'h0000);
		`CHK("ack valid", 1'b1, ackValid)
		`CHK("ack dev", 8'hf0, ackDevice)
		op(4, 16'h0000); // byte reads first, then a halfword read
		`CHK("rd high", 16'h0000, readData)
		op(4, 16'h0000);
		`CHK("rd low", 16'h0013, readData)
		op(5, 16'h0000);
		`CHK("rh", 16'h0013, readData)
		$display("normal transfer done");
	endtask
	task automatic t_roll;
		slow = 1'b1;
		load(16'hfffe, 16'h0004);
		op(1, 16'h0010);
		waitIrq();
		`CHK("term", 2'h2, lastTermination)
		op(6, 16'h0000);
		slow = 1'b0;
		$display("rollover done");
	endtask
	task automatic t_fault;
		logic [7:0] fb[3] = '{8'h04, 8'h20, 8'h80};
		for (int i = 0; i < 3; i++) begin
			load(16'h0000, 16'h0fff);
			op(1, 16'h0010);
			periph = fb[i];
			waitIrq();
			`CHK("term", 2'h3, lastTermination)
			`CHK("status", fb[i], statusByte)
			op(0, 16'h0000);
			`CHK("cc", fb[i][3:0], conditionCode)
			`CHK("irq lost", 1'b0, interruptRequest)
			periph = 8'h00;
		end
		$display("fault termination done");
	endtask
	task automatic t_stop;
		slow = 1'b1;
		load(16'h0000, 16'h0fff);
		op(1, 16'h0030);
		opDevice = 8'h21;
		op(1, 16'h0008);
		`CHK("other dev", 1'b1, transferActive)
		opDevice = 8'hf0;
		op(1, 16'h0008);
		`CHK("stopped", 1'b0, transferActive)
		`CHK("stop irq", 1'b0, interruptRequest)
		op(1, 16'h0030);
		initSwitch = 1'b1;
		@(negedge clk);
		initSwitch = 1'b0;
		`CHK("init", 1'b0, transferActive | readMode)
		slow = 1'b0;
		$display("stop and init done");
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		t_normal();
		t_roll();
		t_fault();
		t_stop();
		stop_test();
	end
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
endmodule // test_block_transfer_channel_control
bind btc_channel btc_channel_props #(.DEV_NUM(DEV_NUM)) prop_u (.clk, .rstn, .initSwitch,
	.senseStatusOp, .outputCommandOp, .writeDataOp, .writeHalfOp, .readDataOp,
	.readHalfOp, .interruptAckOp, .ackValid, .interruptRequest, .transferActive,
	.readMode, .opDevice, .peripheralStatus, .statusByte, .ackDevice, .opData,
	.conditionCode);
